// file: hdl/mcsr_pkg.sv
// constants and carrier types for the modulator control and status bank
package mcsr_pkg;

    // host port layout
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned WORD_W = 32;
    localparam int unsigned SEED_W = 19;
    localparam int unsigned STAT_W = 7;

    // host port address spaces
    localparam logic [2:0] SPACE_BYTE_LAST = 3'h3;
    localparam logic [2:0] SPACE_COMMIT    = 3'h4;
    localparam logic [2:0] SPACE_READ_SEL  = 3'h5;

    // control word indices
    localparam logic [7:0] CW_INT_STATUS  = 8'h08;
    localparam logic [7:0] CW_INT_ENABLE  = 8'h09;
    localparam logic [7:0] CW_CARRIER     = 8'h0a;
    localparam logic [7:0] CW_SYMBOL      = 8'h0b;
    localparam logic [7:0] CW_UPPER_CLAMP = 8'h0c;
    localparam logic [7:0] CW_LOWER_CLAMP = 8'h0d;
    localparam logic [7:0] CW_FIFO_CLEAR  = 8'h0e;
    localparam logic [7:0] CW_BUF_UPDATE  = 8'h0f;
    localparam logic [7:0] CW_SOFT_RESET  = 8'h10;
    localparam logic [7:0] CW_SEED        = 8'h11;
    localparam logic [7:0] CW_FIFO_WRITE  = 8'h12;

    // status and enable bit positions
    localparam int unsigned BIT_FIFO_FULL  = 6;
    localparam int unsigned BIT_FIFO_EMPTY = 5;
    localparam int unsigned BIT_FIFO_OVFL  = 4;
    localparam int unsigned BIT_FIFO_UNFL  = 3;
    localparam int unsigned BIT_DPLL_LOCK  = 2;
    localparam int unsigned BIT_APLL_LOCK  = 1;
    localparam int unsigned BIT_RESET_DONE = 0;

    // reset values
    localparam logic [7:0]  RST_INT_STATUS  = 8'h00;
    localparam logic [7:0]  RST_INT_ENABLE  = 8'h00;
    localparam logic [31:0] RST_CARRIER     = 32'h0000_0000;
    localparam logic [31:0] RST_SYMBOL      = 32'h0000_0000;
    localparam logic [31:0] RST_UPPER_CLAMP = 32'h07ff_ffff;
    localparam logic [31:0] RST_LOWER_CLAMP = 32'h0000_0000;
    localparam logic [18:0] RST_SEED        = 19'h0_0000;
    localparam logic [31:0] RST_MASTER      = 32'h0000_0000;

    // hardware reset hold time, device clock cycles
    localparam int unsigned RESET_HOLD_CYCLES = 10;

    typedef struct packed {
        logic        chip_enable_b;
        logic        write_b;
        logic [2:0]  addr;
        logic [7:0]  data;
    } mcsr_port_t;

    typedef struct packed {
        logic [31:0] carrier_phase_step;
        logic [31:0] symbol_phase_step;
        logic [31:0] loop_filter_upper_clamp;
        logic [31:0] loop_filter_lower_clamp;
        logic [18:0] filter_seed;
    } mcsr_settings_t;

    typedef struct packed {
        logic fifo_clear_strobe;
        logic buffer_update_strobe;
        logic fifo_write_strobe;
    } mcsr_strobes_t;

endpackage

// file: hdl/mcsr_regs.sv
// control word bank behind the 8-bit host control port
`timescale 1ns/1ps
`default_nettype none

module mcsr_regs
(
    // clock and reset
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_rst_b,
    // host control port pins
    input  wire mcsr_pkg::mcsr_port_t     i_port,
    output logic [7:0]                    o_control_data,
    output logic                          o_control_data_oe,
    // conditions from the datapath, same clock
    input  wire logic [6:0]               i_status,
    // to the datapath
    output mcsr_pkg::mcsr_settings_t      o_settings,
    output mcsr_pkg::mcsr_strobes_t       o_strobes,
    output logic                          o_soft_reset,
    output logic                          o_irq
);

    typedef enum logic [1:0]
    {
        MCSR_IDLE  = 2'b00,
        MCSR_WRITE = 2'b01,
        MCSR_READ  = 2'b10
    } mcsr_phase_t;

    // three-stage synchroniser on every port pin
    mcsr_pkg::mcsr_port_t sync1;
    mcsr_pkg::mcsr_port_t sync2;
    mcsr_pkg::mcsr_port_t sync3;
    mcsr_pkg::mcsr_port_t port;
    mcsr_phase_t          phase;
    mcsr_phase_t          next_phase;
    logic [31:0]          master_register;
    logic [7:0]           read_select;
    logic [7:0]           int_status;
    logic [7:0]           int_enable;
    logic                 write_event;
    logic                 commit;
    logic [7:0]           commit_word;
    logic [31:0]          read_word;

    // an address space that carries one byte of the master register
    function automatic logic is_byte_space(input logic [2:0] space);
        return space <= mcsr_pkg::SPACE_BYTE_LAST;
    endfunction

    // completed host write into one address space
    function automatic logic space_hit(input logic       done,
                                       input logic [2:0] space,
                                       input logic [2:0] target);
        return done && (space == target);
    endfunction

    // commit aimed at one trigger word
    function automatic logic word_hit(input logic       fire,
                                      input logic [7:0] word,
                                      input logic [7:0] target);
        return fire && (word == target);
    endfunction

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            sync1 <= '1;
            sync2 <= '1;
            sync3 <= '1;
            port  <= '1;
        end
        else
        begin
            sync1 <= i_port;
            sync2 <= sync1;
            sync3 <= sync2;
            // a change counts only once two stages agree
            if (sync2 == sync3)
            begin
                port <= sync3;
            end
        end
    end

    // write taken once per write pulse, on its completion
    always_comb
    begin
        next_phase = MCSR_IDLE;
        if (!port.chip_enable_b)
        begin
            next_phase = port.write_b ? MCSR_READ : MCSR_WRITE;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            phase <= MCSR_IDLE;
        end
        else
        begin
            phase <= next_phase;
        end
    end

    // write and its latched address and data held by the last filtered sample
    logic [2:0] held_addr;
    logic [7:0] held_data;

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            held_addr <= 3'h0;
            held_data <= 8'h00;
        end
        else if (next_phase == MCSR_WRITE)
        begin
            held_addr <= port.addr;
            held_data <= port.data;
        end
    end

    assign write_event = (phase == MCSR_WRITE) && (next_phase != MCSR_WRITE);
    assign commit      = space_hit(write_event, held_addr, mcsr_pkg::SPACE_COMMIT)
                         && (held_data != mcsr_pkg::CW_SOFT_RESET);
    assign commit_word = held_data;

    // master register bytes and read word select
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            master_register <= mcsr_pkg::RST_MASTER;
        end
        else if (write_event && is_byte_space(held_addr))
        begin
            master_register[held_addr[1:0]*8 +: 8] <= held_data;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            read_select <= mcsr_pkg::CW_INT_STATUS;
        end
        else if (space_hit(write_event, held_addr, mcsr_pkg::SPACE_READ_SEL))
        begin
            read_select <= held_data;
        end
    end

    // soft reset level
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            o_soft_reset <= 1'b0;
        end
        else if (space_hit(write_event, held_addr, mcsr_pkg::SPACE_COMMIT))
        begin
            o_soft_reset <= (held_data == mcsr_pkg::CW_SOFT_RESET);
        end
    end

    // stored control words
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            int_enable                         <= mcsr_pkg::RST_INT_ENABLE;
            o_settings.carrier_phase_step      <= mcsr_pkg::RST_CARRIER;
            o_settings.symbol_phase_step       <= mcsr_pkg::RST_SYMBOL;
            o_settings.loop_filter_upper_clamp <= mcsr_pkg::RST_UPPER_CLAMP;
            o_settings.loop_filter_lower_clamp <= mcsr_pkg::RST_LOWER_CLAMP;
            o_settings.filter_seed             <= mcsr_pkg::RST_SEED;
        end
        else if (commit)
        begin
            if (commit_word == mcsr_pkg::CW_INT_ENABLE)
            begin
                int_enable <= {1'b0, master_register[6:0]};
            end
            else if (commit_word == mcsr_pkg::CW_CARRIER)
            begin
                o_settings.carrier_phase_step <= master_register;
            end
            else if (commit_word == mcsr_pkg::CW_SYMBOL)
            begin
                o_settings.symbol_phase_step <= master_register;
            end
            else if (commit_word == mcsr_pkg::CW_UPPER_CLAMP)
            begin
                o_settings.loop_filter_upper_clamp <= master_register;
            end
            else if (commit_word == mcsr_pkg::CW_LOWER_CLAMP)
            begin
                o_settings.loop_filter_lower_clamp <= master_register;
            end
            else if (commit_word == mcsr_pkg::CW_SEED)
            begin
                o_settings.filter_seed <= master_register[18:0];
            end
        end
    end

    // one-cycle strobes, nothing stored
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            o_strobes <= '0;
        end
        else
        begin
            o_strobes.fifo_clear_strobe    <= word_hit(commit, commit_word,
                                                       mcsr_pkg::CW_FIFO_CLEAR);
            o_strobes.buffer_update_strobe <= word_hit(commit, commit_word,
                                                       mcsr_pkg::CW_BUF_UPDATE);
            o_strobes.fifo_write_strobe    <= word_hit(commit, commit_word,
                                                       mcsr_pkg::CW_FIFO_WRITE);
        end
    end

    // status mirrors the datapath conditions, bit 7 always zero
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            int_status <= mcsr_pkg::RST_INT_STATUS;
        end
        else
        begin
            int_status <= {1'b0, i_status};
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            o_irq <= 1'b0;
        end
        else
        begin
            o_irq <= |({1'b0, i_status} & int_enable);
        end
    end

    // readback of the selected word, byte chosen by the address pins
    always_comb
    begin
        read_word = 32'h0000_0000;
        if (read_select == mcsr_pkg::CW_INT_STATUS)
            read_word = {24'h00_0000, int_status};
        else if (read_select == mcsr_pkg::CW_INT_ENABLE)
            read_word = {24'h00_0000, int_enable};
        else if (read_select == mcsr_pkg::CW_CARRIER)
            read_word = o_settings.carrier_phase_step;
        else if (read_select == mcsr_pkg::CW_SYMBOL)
            read_word = o_settings.symbol_phase_step;
        else if (read_select == mcsr_pkg::CW_UPPER_CLAMP)
            read_word = o_settings.loop_filter_upper_clamp;
        else if (read_select == mcsr_pkg::CW_LOWER_CLAMP)
            read_word = o_settings.loop_filter_lower_clamp;
        else if (read_select == mcsr_pkg::CW_SEED)
            read_word = {13'h0000, o_settings.filter_seed};
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            o_control_data    <= 8'h00;
            o_control_data_oe <= 1'b0;
        end
        else
        begin
            o_control_data    <= read_word[port.addr[1:0]*8 +: 8];
            // only the byte spaces drive the bus, avoiding contention elsewhere
            o_control_data_oe <= (next_phase == MCSR_READ)
                                 && is_byte_space(port.addr);
        end
    end

endmodule

`default_nettype wire

// file: tb/mcsr_regs_props.sv
// port-level checks for the control word bank
`timescale 1ns/1ps
`default_nettype none
module mcsr_regs_props
(
    // clock and reset
    input wire logic                     i_ref_clk,
    input wire logic                     i_rst_b,
    // inputs
    input wire mcsr_pkg::mcsr_port_t     i_port,
    input wire logic [6:0]               i_status,
    // outputs
    input wire mcsr_pkg::mcsr_settings_t o_settings,
    input wire mcsr_pkg::mcsr_strobes_t  o_strobes,
    input wire logic                     o_soft_reset,
    input wire logic                     o_irq
);
    localparam mcsr_pkg::mcsr_settings_t RST_SET = {64'h0, 32'h07ff_ffff, 51'h0};
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);
    // a space-4 write seen at the moment its strobe ends
    sequence s_space4;
        (!i_port.chip_enable_b && !i_port.write_b && i_port.addr == 3'h4)[*3]
        ##1 i_port.write_b;
    endsequence
    sequence s_cmd(logic [7:0] d);
        s_space4 ##0 (i_port.data == d);
    endsequence
    property p_reset_vals;
        $past(i_rst_b) == 1'b0 |-> o_settings == RST_SET && o_strobes == 3'h0
            && !o_soft_reset && !o_irq;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("outputs differ from reset values");
    property p_strobe_pulse;
        o_strobes != 3'h0 |-> $onehot(o_strobes) ##1 o_strobes == 3'h0;
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse)
        else $error("strobe not a single one-cycle pulse");
    // no setting, soft reset or strobe may move while the port has been quiet
    property p_idle_stable;
        i_port.chip_enable_b [*8] |=> $stable(o_settings) && $stable(o_soft_reset)
            && o_strobes == 3'h0;
    endproperty
    a_idle_stable: assert property (p_idle_stable)
        else $error("bank changed with port idle");
    property p_fifo_clr;
        s_cmd(8'h0e) |-> ##[1:8] o_strobes.fifo_clear_strobe;
    endproperty
    a_fifo_clr: assert property (p_fifo_clr)
        else $error("no fifo clear strobe");
    property p_buf_upd;
        s_cmd(8'h0f) |-> ##[1:8] o_strobes.buffer_update_strobe;
    endproperty
    a_buf_upd: assert property (p_buf_upd)
        else $error("no buffer update strobe");
    property p_fifo_wr;
        s_cmd(8'h12) |-> ##[1:8] o_strobes.fifo_write_strobe;
    endproperty
    a_fifo_wr: assert property (p_fifo_wr)
        else $error("no fifo write strobe");
    property p_soft_set;
        s_cmd(8'h10) |-> ##[1:8] o_soft_reset;
    endproperty
    a_soft_set: assert property (p_soft_set)
        else $error("soft reset not raised");
    property p_soft_clr;
        s_space4 ##0 (i_port.data != 8'h10) |-> ##[1:8] !o_soft_reset;
    endproperty
    a_soft_clr: assert property (p_soft_clr)
        else $error("soft reset not released");
    property p_irq_quiet;
        $past(i_status) == 7'h00 |-> !o_irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("interrupt without status");
endmodule
`default_nettype wire

// file: tb/mcsr_host.sv
// host processor model on the 8-bit control port
`timescale 1ns/1ps
`default_nettype none
module mcsr_host
(
    // clock
    input  wire logic                i_ref_clk,
    // read side
    input  wire logic [7:0]          i_control_data,
    input  wire logic                i_control_data_oe,
    // pins toward the bank
    output var mcsr_pkg::mcsr_port_t o_port
);
    initial o_port = 13'h1fff;
    task automatic cyc(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask
    // four clocks per phase keeps the strobe longer than the two clocks the filter needs to see it agree
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        cyc(1);
        o_port = {2'b00, a, d};
        cyc(4);
        o_port[12:11] = 2'b11;
        cyc(4);
        // a released bus must not keep showing the old value
        o_port[10:0] = ~o_port[10:0];
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic oe);
        cyc(1);
        o_port = {2'b01, a, o_port[7:0]};
        cyc(6);
        d = i_control_data;
        oe = i_control_data_oe;
        o_port[12] = 1'b1;
        cyc(4);
    endtask
endmodule
`default_nettype wire

// file: tb/mcsr_regs_tb.sv
// self-checking bench for the control word bank
`timescale 1ns/1ps
`default_nettype none
module mcsr_regs_tb;
    logic                     i_ref_clk;
    logic                     i_rst_b;
    logic [6:0]               i_status;
    mcsr_pkg::mcsr_port_t     port;
    logic [7:0]               cdata;
    logic                     cdata_oe;
    logic [7:0]               rd_data;
    logic                     rd_oe;
    mcsr_pkg::mcsr_settings_t o_settings;
    mcsr_pkg::mcsr_settings_t exp_set;
    mcsr_pkg::mcsr_strobes_t  o_strobes;
    logic                     o_soft_reset;
    logic                     o_irq;
    logic [31:0]              v;
    logic [7:0]               en;
    logic [2:0]               notes[$];
    int                       errors = 0;
    int                       comparisons = 0;
    int                       cycles = 0;

    mcsr_regs dut_u
    (
        .i_ref_clk        (i_ref_clk),
        .i_rst_b          (i_rst_b),
        .i_port           (port),
        .o_control_data   (cdata),
        .o_control_data_oe(cdata_oe),
        .i_status         (i_status),
        .o_settings       (o_settings),
        .o_strobes        (o_strobes),
        .o_soft_reset     (o_soft_reset),
        .o_irq            (o_irq)
    );
    mcsr_host host_u
    (
        .i_ref_clk        (i_ref_clk),
        .i_control_data   (cdata),
        .i_control_data_oe(cdata_oe),
        .o_port           (port)
    );

    initial
    begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end

    task automatic check(input logic [159:0] seen, input logic [159:0] want);
        comparisons++;
        if (seen !== want)
        begin
            errors++;
            $display("unexpected at %0t: seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic put(input logic [7:0] w, input logic [31:0] d);
        for (int b = 0; b < 4; b++)
            host_u.wr(3'(b), d[8*b +: 8]);
        host_u.wr(3'h4, w);
        host_u.cyc(4);
    endtask

    task automatic peek(input logic [7:0] w, input logic [2:0] b, input logic [7:0] want);
        host_u.wr(3'h5, w);
        host_u.rd(b, rd_data, rd_oe);
        check({rd_oe, rd_data}, {1'b1, want});
    endtask

    task automatic restart;
        i_rst_b = 1'b0;
        repeat (16) @(negedge i_ref_clk);
        i_rst_b = 1'b1;
        host_u.cyc(4);
        check(o_settings, {64'h0, 32'h07ff_ffff, 51'h0});
        check({o_strobes, o_soft_reset, o_irq}, 5'h0);
        peek(8'h09, 3'h0, 8'h00);
    endtask

    // strobes are matched in order against the notes left by the driver
    always @(negedge i_ref_clk)
    begin
        cycles++;
        if (o_strobes !== 3'h0)
            check(o_strobes, notes.size() ? notes.pop_front() : 3'h0);
        if (cycles == 4000)
        begin
            errors++;
            tally_and_finish();
        end
    end

    initial
    begin
        v = $urandom(36);
        i_status = 7'($urandom());
        restart();
        exp_set = {$urandom(), $urandom(), $urandom(), $urandom(), 19'($urandom())};
        put(8'h0a, exp_set.carrier_phase_step);
        put(8'h0b, exp_set.symbol_phase_step);
        put(8'h0c, exp_set.loop_filter_upper_clamp);
        put(8'h0d, exp_set.loop_filter_lower_clamp);
        put(8'h11, {13'($urandom()), exp_set.filter_seed});
        put(8'h08, $urandom());
        put(8'h07, $urandom());
        check(o_settings, exp_set);
        peek(8'h0a, 3'h2, exp_set.carrier_phase_step[23:16]);
        peek(8'h0b, 3'h3, exp_set.symbol_phase_step[31:24]);
        peek(8'h0c, 3'h1, exp_set.loop_filter_upper_clamp[15:8]);
        peek(8'h0d, 3'h0, exp_set.loop_filter_lower_clamp[7:0]);
        peek(8'h11, 3'h2, {5'h00, exp_set.filter_seed[18:16]});
        v = $urandom() | 32'h1;
        en = {1'b0, v[6:0]};
        put(8'h09, v);
        peek(8'h09, 3'h0, en);
        repeat (8)
        begin
            @(negedge i_ref_clk);
            i_status = 7'($urandom());
            host_u.cyc(2);
            check(o_irq, |(i_status & en[6:0]));
            peek(8'h08, 3'h0, {1'b0, i_status});
        end
        notes.push_back(3'h4);
        host_u.wr(3'h4, 8'h0e);
        notes.push_back(3'h2);
        host_u.wr(3'h4, 8'h0f);
        notes.push_back(3'h1);
        host_u.wr(3'h4, 8'h12);
        host_u.wr(3'h4, 8'h10);
        host_u.cyc(4);
        check(o_soft_reset, 1'b1);
        host_u.wr(3'h0, 8'h10);
        host_u.cyc(8);
        check({o_soft_reset, o_settings}, {1'b1, exp_set});
        v = $urandom();
        exp_set.loop_filter_lower_clamp = v;
        put(8'h0d, v);
        check({o_soft_reset, o_settings}, {1'b0, exp_set});
        check(notes.size(), 0);
        restart();
        tally_and_finish();
    end
endmodule

bind mcsr_regs mcsr_regs_props chk_u
(
    .i_ref_clk   (i_ref_clk),
    .i_rst_b     (i_rst_b),
    .i_port      (i_port),
    .i_status    (i_status),
    .o_settings  (o_settings),
    .o_strobes   (o_strobes),
    .o_soft_reset(o_soft_reset),
    .o_irq       (o_irq)
);
`default_nettype wire
